/* design/sso_sensor.sv */
// Output and chaining logic of one contactless safety sensor.
// Assumes synchronous inputs, the link towards the monitor on one side and
// the chain inputs, straps and buttons as plain ports on the other.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "sso_regs.svh"

module sso_sensor import sso_pkg::*; #(
  parameter int TEST_PULSE_CYC = `SSO_TEST_PULSE_CYC,
  parameter int TEST_PERIOD_CYC = `SSO_TEST_PERIOD_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link towards the monitor and gateway, or the previous member.
  sso_link_if.sensor link,
  // Chain inputs from the next member, or supply on the last one.
  input wire logic safetyInA,
  input wire logic safetyInB,
  // Sensing head.
  input wire logic actuatorPresent,
  // Variant and option straps.
  input wire sso_variant_e variant,
  input wire logic estopMonEnable,
  input wire logic [`SSO_POS_W-1:0] chainPos,
  // Contactor feedback loop and buttons.
  input wire logic feedbackClosed,
  input wire logic resetButton,
  input wire logic estopHealthy,
  input wire logic ackButton,
  // Diagnostic daisy chain towards the next member.
  input wire logic diagFromNext,
  output logic diagResetToNext,
  // Contactor drives and status.
  output logic contactorFirst,
  output logic contactorSecond,
  output logic estopFault,
  output logic outputsOn
);

  // ****************************************************************
  // Self-test pulse timing
  // ****************************************************************
  localparam logic [`SSO_CNT_W-1:0] PulseW = `SSO_CNT_W'(TEST_PULSE_CYC);
  localparam logic [`SSO_CNT_W-1:0] PeriodLast =
    `SSO_CNT_W'(TEST_PERIOD_CYC - 1);
  localparam logic [`SSO_CNT_W-1:0] HalfPeriod =
    `SSO_CNT_W'(TEST_PERIOD_CYC / 2);

  logic [`SSO_CNT_W-1:0] testCnt_q;
  logic [`SSO_CNT_W-1:0] testCnt_d;
  wire logic pulseA;
  wire logic pulseB;

  // staggered test pulses
  // Channel A is tested at the start of the period and channel B half a
  // period later, so a short between the channels shows at the monitor as
  // a channel that never drops.
  assign testCnt_d = (testCnt_q >= PeriodLast) ? '0 : testCnt_q + 1'b1;
  assign pulseA = (testCnt_q < PulseW);
  assign pulseB = (testCnt_q >= HalfPeriod) &&
                  (testCnt_q < HalfPeriod + PulseW);

  // ****************************************************************
  // Enabling conditions
  // ****************************************************************
  logic estopFault_q;
  logic estopFault_d;
  logic btnPrev_q;
  sso_state_e state_q;
  sso_state_e state_d;
  wire logic chainOk;
  wire logic guardOk;
  wire logic diagEnabled;
  wire logic estopClear;
  wire logic btnRelease;

  // chain end supplied
  // On the last member both inputs are tied to supply, so only the own
  // actuator and the latched stop chain fault decide.
  assign chainOk = safetyInA & safetyInB;
  assign guardOk = chainOk & actuatorPresent & ~estopFault_q;

  // chain position range
  // Position zero means the member has no serial diagnostics; positions
  // one to the maximum count are the valid chain slots.
  assign diagEnabled = (chainPos != '0) &&
                       (chainPos <= `SSO_POS_W'(`SSO_MAX_CHAIN));

  // diagnostic reset command
  // The clear works only while the stop chain is healthy again; a fault
  // still present is set in the same cycle and wins over the clear.
  assign estopClear = ackButton | (link.diagResetCmd & diagEnabled);
  assign estopFault_d = estopMonEnable &
                        (~estopHealthy | (estopFault_q & ~estopClear));

  assign btnRelease = btnPrev_q & ~resetButton;

  // ****************************************************************
  // Enable state machine
  // ****************************************************************
  // The feedback loop is only judged while the contactors are dropped;
  // once they pull in, their break contacts open on purpose.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (guardOk) begin
          case (variant)
            VAR_PLAIN: begin
              state_d = ST_ON;
            end
            // level, no edge
            // A button in the loop simply closes it, so no edge is seen.
            VAR_AUTO_RESET: begin
              if (feedbackClosed) begin
                state_d = ST_ON;
              end
            end
            VAR_MANUAL_RESET: begin
              if (feedbackClosed && resetButton) begin
                state_d = ST_ARMED;
              end
            end
            default: begin
              state_d = ST_OFF;
            end
          endcase
        end
      end
      ST_ARMED: begin
        if (!guardOk || !feedbackClosed) begin
          state_d = ST_OFF;
        end else if (btnRelease) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (!guardOk) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  logic outA_q;
  logic outB_q;
  logic on_q;
  logic diagStatus_q;
  logic diagReset_q;
  wire logic onNow;

  // Enabling is gated by the current guard state as well, so an opening
  // drops the outputs at the very next edge, never a cycle later.
  assign onNow = (state_d == ST_ON) && guardOk;

  // one stage per member
  // Each member re-registers the chain, adding its own reaction time.
  always_ff @(posedge clk) begin
    if (rst) begin
      testCnt_q <= '0;
      state_q <= ST_OFF;
      btnPrev_q <= 1'b0;
      estopFault_q <= 1'b0;
      outA_q <= 1'b0;
      outB_q <= 1'b0;
      on_q <= 1'b0;
    end else begin
      testCnt_q <= testCnt_d;
      state_q <= state_d;
      btnPrev_q <= resetButton;
      estopFault_q <= estopFault_d;
      outA_q <= onNow & ~pulseA;
      outB_q <= onNow & ~pulseB;
      on_q <= onNow;
    end
  end

  // diagnostic daisy chain
  // Status of this member merges with the members behind it, and the
  // gateway's reset command travels on towards them one stage per member.
  always_ff @(posedge clk) begin
    if (rst) begin
      diagStatus_q <= 1'b0;
      diagReset_q <= 1'b0;
    end else begin
      diagStatus_q <= diagEnabled & (estopFault_q | ~guardOk | diagFromNext);
      diagReset_q <= link.diagResetCmd & diagEnabled;
    end
  end

  // ****************************************************************
  // Port drives
  // ****************************************************************
  // The contactor drives mirror the safety outputs, test pulses included;
  // positive-action contactors ride through the short dips.
  assign link.safetyOutA = outA_q;
  assign link.safetyOutB = outB_q;
  assign link.diagStatus = diagStatus_q;
  assign contactorFirst = outA_q;
  assign contactorSecond = outB_q;
  assign estopFault = estopFault_q;
  assign outputsOn = on_q;
  assign diagResetToNext = diagReset_q;
endmodule

/* design/sso_regs.svh */
// Timing counts, chain limits and register map for the safety output chain.
// Assumes a 20 MHz system clock shared by the sensor and monitor ends.
`ifndef SSO_REGS_SVH
`define SSO_REGS_SVH

// ****************************************************************
// Clock rate
// ****************************************************************
`define SSO_CLK_KHZ 20000

// ****************************************************************
// Self-test pulse timing of the sensor outputs
// ****************************************************************
`define SSO_TEST_PULSE_US 250
`define SSO_TEST_PULSE_CYC ((`SSO_TEST_PULSE_US * `SSO_CLK_KHZ) / 1000)
`define SSO_TEST_PERIOD_MS 10
`define SSO_TEST_PERIOD_CYC (`SSO_TEST_PERIOD_MS * `SSO_CLK_KHZ)

// ****************************************************************
// Monitor tolerances
// ****************************************************************
`define SSO_BLANK_MS 1
`define SSO_BLANK_CYC (`SSO_BLANK_MS * `SSO_CLK_KHZ)
`define SSO_DISCREP_MS 100
`define SSO_DISCREP_CYC (`SSO_DISCREP_MS * `SSO_CLK_KHZ)

// ****************************************************************
// Chain limit and timer width
// ****************************************************************
`define SSO_MAX_CHAIN 31
`define SSO_POS_W 5
`define SSO_CNT_W 24

// ****************************************************************
// Monitor register map
// ****************************************************************
`define SSO_REG_CTRL 4'h0
`define SSO_REG_STATUS 4'h4
`define SSO_CTRL_DIAG_RESET 0
`define SSO_CTRL_CLR_FAULT 1
`define SSO_ST_ENABLE 0
`define SSO_ST_DISCREP 1
`define SSO_ST_CHAIN_FAULT 2
`define SSO_ST_CH_A 3
`define SSO_ST_CH_B 4

`endif

/* design/sso_pkg.sv */
// Types shared by the sensor end and the monitor end of the chain.
// Assumes the constants header is included by each user where needed.
package sso_pkg;

  // Output enabling behaviour selected by the sensor's variant straps.
  typedef enum logic [1:0] {
    VAR_PLAIN = 2'b00,
    VAR_AUTO_RESET = 2'b01,
    VAR_MANUAL_RESET = 2'b10
  } sso_variant_e;

  // Enable state machine, Gray coded along off, armed, on.
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ARMED = 2'b01,
    ST_ON = 2'b11
  } sso_state_e;

endpackage

/* design/sso_link_if.sv */
// Link between the first sensor of a chain and the monitor with gateway.
// Assumes both ends run on the same clock; the bench joins them here.
`timescale 1ns/1ps

interface sso_link_if (
  input wire logic clk
);
  logic safetyOutA;
  logic safetyOutB;
  logic diagStatus;
  logic diagResetCmd;

  modport sensor (
    input clk,
    output safetyOutA,
    output safetyOutB,
    output diagStatus,
    input diagResetCmd
  );

  modport monitor (
    input clk,
    input safetyOutA,
    input safetyOutB,
    input diagStatus,
    output diagResetCmd
  );
endinterface

/* design/sso_blank_filter.sv */
// Blanking filter for one safety input channel of the monitor.
// Assumes a synchronous input; a low shorter than the blank time is hidden.
`timescale 1ns/1ps

module sso_blank_filter #(
  parameter int BLANK_CYC = 20000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw channel and filtered level.
  input wire logic chanIn,
  output logic chanOut
);
  `include "sso_regs.svh"

  logic [`SSO_CNT_W-1:0] lowCnt_q;
  logic [`SSO_CNT_W-1:0] lowCnt_d;
  logic chanOut_q;
  logic chanOut_d;
  wire logic blankExpired;

  // Only a low that outlasts the blank time counts as an opening.
  assign blankExpired = (lowCnt_q >= `SSO_CNT_W'(BLANK_CYC));
  assign lowCnt_d = chanIn ? '0 :
                    (blankExpired ? lowCnt_q : lowCnt_q + 1'b1);
  assign chanOut_d = chanIn ? 1'b1 : (blankExpired ? 1'b0 : chanOut_q);
  assign chanOut = chanOut_q;

  // Counter and filtered level.
  always_ff @(posedge clk) begin
    if (rst) begin
      lowCnt_q <= '0;
      chanOut_q <= 1'b0;
    end else begin
      lowCnt_q <= lowCnt_d;
      chanOut_q <= chanOut_d;
    end
  end
endmodule

/* design/sso_monitor.sv */
// Dual-channel safety monitor with diagnostic gateway, the far end.
// Assumes the first sensor of the chain drives its end of the link.
`timescale 1ns/1ps
`include "sso_regs.svh"

module sso_monitor import sso_pkg::*; #(
  parameter int BLANK_CYC = `SSO_BLANK_CYC,
  parameter int DISCREP_CYC = `SSO_DISCREP_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link to the first sensor.
  sso_link_if.monitor link,
  // Software register port.
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Machine enable towards the load.
  output logic machineEnable
);

  // ****************************************************************
  // Blanked channels
  // ****************************************************************
  logic [1:0] rawCh;
  logic [1:0] filtCh;
  assign rawCh = {link.safetyOutB, link.safetyOutA};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gChan
      sso_blank_filter #(.BLANK_CYC(BLANK_CYC)) uFilt (
        .clk(clk),
        .rst(rst),
        .chanIn(rawCh[g]),
        .chanOut(filtCh[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Discrepancy supervision
  // ****************************************************************
  logic [`SSO_CNT_W-1:0] discCnt_q;
  logic [`SSO_CNT_W-1:0] discCnt_d;
  logic discFault_q;
  logic discFault_d;
  logic enable_q;
  logic diagCmd_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire logic mismatch;
  wire logic discHit;
  wire logic ctrlWr;
  wire logic clrFault;

  // no cross-short check
  // A mismatch is tolerated for the discrepancy time; the sensor's own
  // staggered test pulses cover shorted channels instead.
  assign mismatch = filtCh[0] ^ filtCh[1];
  assign discHit = mismatch && (discCnt_q >= `SSO_CNT_W'(DISCREP_CYC));
  assign discCnt_d = mismatch ? (discHit ? discCnt_q : discCnt_q + 1'b1)
                              : '0;
  assign ctrlWr = regWr && (regAddr == `SSO_REG_CTRL);
  assign clrFault = ctrlWr && regWdata[`SSO_CTRL_CLR_FAULT];
  // The set wins over a software clear in the same cycle.
  assign discFault_d = discHit | (discFault_q & ~clrFault);

  // Status read back, unmapped addresses read zero.
  always_comb begin
    rdata_d = 32'h0;
    if (regRd && regAddr == `SSO_REG_STATUS) begin
      rdata_d[`SSO_ST_ENABLE] = enable_q;
      rdata_d[`SSO_ST_DISCREP] = discFault_q;
      rdata_d[`SSO_ST_CHAIN_FAULT] = link.diagStatus;
      rdata_d[`SSO_ST_CH_A] = filtCh[0];
      rdata_d[`SSO_ST_CH_B] = filtCh[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      discCnt_q <= '0;
      discFault_q <= 1'b0;
      enable_q <= 1'b0;
      diagCmd_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      discCnt_q <= discCnt_d;
      discFault_q <= discFault_d;
      enable_q <= filtCh[0] & filtCh[1] & ~discFault_d;
      diagCmd_q <= ctrlWr && regWdata[`SSO_CTRL_DIAG_RESET];
      rdata_q <= rdata_d;
    end
  end

  assign link.diagResetCmd = diagCmd_q;
  assign machineEnable = enable_q;
  assign regRdata = rdata_q;
endmodule

/* dv/sso_link_asserts.sv */
// Link checks between the first sensor of a chain and the monitor.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module sso_link_asserts #(
  parameter int TEST_PULSE_CYC = 4,
  parameter int TEST_PERIOD_CYC = 40
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link signals.
  input wire logic safetyOutA,
  input wire logic safetyOutB,
  input wire logic diagStatus,
  input wire logic diagResetCmd
);
  // Half period puts the two channel pulses as far apart as possible.
  localparam int HALF = TEST_PERIOD_CYC / 2;
  localparam int GAP_M1 = HALF - TEST_PULSE_CYC - 1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // Test pulse shape; the repeat counts match a four-cycle pulse.
  // ****************************************************************
  property p_a_width;
    $fell(safetyOutA) && safetyOutB |=>
      !safetyOutA [*3] ##1 (safetyOutA || !safetyOutB);
  endproperty
  a_a_width: assert property (p_a_width)
    else $error("channel A test pulse has the wrong width");

  property p_b_width;
    $fell(safetyOutB) && safetyOutA |=>
      !safetyOutB [*3] ##1 (safetyOutB || !safetyOutA);
  endproperty
  a_b_width: assert property (p_b_width)
    else $error("channel B test pulse has the wrong width");

  property p_a_to_b;
    $rose(safetyOutA) && safetyOutB && $past(safetyOutB) ##GAP_M1
      (safetyOutA && safetyOutB) |=> !safetyOutB;
  endproperty
  a_a_to_b: assert property (p_a_to_b)
    else $error("channel B pulse not half a period after A");

  property p_b_to_a;
    $rose(safetyOutB) && safetyOutA && $past(safetyOutA) ##GAP_M1
      (safetyOutA && safetyOutB) |=> !safetyOutA;
  endproperty
  a_b_to_a: assert property (p_b_to_a)
    else $error("channel A pulse not half a period after B");

  property p_pulse_due;
    safetyOutA && safetyOutB |-> ##[1:HALF] !(safetyOutA && safetyOutB);
  endproperty
  a_pulse_due: assert property (p_pulse_due)
    else $error("no test pulse within half a period");

  // Channels may differ only for the length of one test pulse.
  property p_mismatch;
    safetyOutA != safetyOutB |->
      ##[1:TEST_PULSE_CYC] (safetyOutA == safetyOutB);
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("channels differ longer than a test pulse");

  property p_cmd_pulse;
    diagResetCmd |=> !diagResetCmd;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("diagnostic reset command longer than one cycle");
endmodule

/* dv/safety_sensor_output_chain_bench.sv */
// Bench joining one sensor to the monitor, with a cycle model of both.
// Assumes shortened pulse, period, blank and discrepancy counts.
`timescale 1ns/1ps
`include "sso_regs.svh"

`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module safety_sensor_output_chain_bench import sso_pkg::*;;
  localparam int TP = 4;
  localparam int PER = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic inA = 1'b1, inB = 1'b1, act = 1'b1, fb = 1'b1, btn = 1'b0;
  logic healthy = 1'b1, ack = 1'b0, dfn = 1'b0, emon = 1'b1;
  logic [`SSO_POS_W-1:0] pos = '0;
  sso_variant_e variant = VAR_PLAIN;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [31:0] regRdata;
  logic machineEnable, dRst, kA, kB, eFlt, on;
  logic gOk, expA, expB, expDr, expCmd, flt;
  int errors = 0, nChecks = 0, st, cnt;

  // ****************************************************************
  // Design under test
  // ****************************************************************
  sso_link_if sso_link_if_inst (.clk(clk));
  wire lA = sso_link_if_inst.safetyOutA;
  wire lB = sso_link_if_inst.safetyOutB;
  wire lCmd = sso_link_if_inst.diagResetCmd;

  sso_sensor #(.TEST_PULSE_CYC(TP), .TEST_PERIOD_CYC(PER)) sso_sensor_inst (
    .clk(clk), .rst(rst), .link(sso_link_if_inst.sensor),
    .safetyInA(inA), .safetyInB(inB), .actuatorPresent(act),
    .variant(variant), .estopMonEnable(emon), .chainPos(pos),
    .feedbackClosed(fb), .resetButton(btn), .estopHealthy(healthy),
    .ackButton(ack), .diagFromNext(dfn), .diagResetToNext(dRst),
    .contactorFirst(kA), .contactorSecond(kB), .estopFault(eFlt),
    .outputsOn(on));

  sso_monitor #(.BLANK_CYC(8), .DISCREP_CYC(50)) sso_monitor_inst (
    .clk(clk), .rst(rst), .link(sso_link_if_inst.monitor),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .machineEnable(machineEnable));

  // A second monitor blanks for less than one test pulse, so each pulse
  // shows as a mismatch that outlasts its short discrepancy time.
  sso_link_if sso_link_if_short (.clk(clk));
  logic [31:0] shortRdata;
  logic shortEnable;
  assign sso_link_if_short.safetyOutA = lA;
  assign sso_link_if_short.safetyOutB = lB;
  assign sso_link_if_short.diagStatus = sso_link_if_inst.diagStatus;

  sso_monitor #(.BLANK_CYC(1), .DISCREP_CYC(2)) sso_monitor_short_inst (
    .clk(clk), .rst(rst), .link(sso_link_if_short.monitor),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(shortRdata), .machineEnable(shortEnable));

  sso_link_asserts #(.TEST_PULSE_CYC(TP), .TEST_PERIOD_CYC(PER))
    sso_link_asserts_inst (.clk(clk), .rst(rst), .safetyOutA(lA),
    .safetyOutB(lB), .diagStatus(sso_link_if_inst.diagStatus),
    .diagResetCmd(lCmd));

  // Free-running 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Reference model, sampling the same edge values as the design
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      st = 0;
      cnt = 0;
      flt = 0;
      {expA, expB, expDr, expCmd} = 4'h0;
    end else begin
      gOk = inA && inB && act && !flt;
      if (!emon) flt = 0;
      else if (!healthy) flt = 1;
      else if (ack || (pos != 0 && lCmd)) flt = 0;
      case (variant)
        VAR_PLAIN: st = gOk ? 2 : 0;
        VAR_AUTO_RESET: st = !gOk ? 0 : (st == 2 || fb) ? 2 : 0;
        VAR_MANUAL_RESET: st = !gOk ? 0 : st == 2 ? 2 : st == 1 ?
          (!fb ? 0 : !btn ? 2 : 1) : (fb && btn) ? 1 : 0;
        default: st = 0;
      endcase
      expA = st == 2 && !(cnt < TP);
      expB = st == 2 && !(cnt >= PER / 2 && cnt < PER / 2 + TP);
      cnt = cnt == PER - 1 ? 0 : cnt + 1;
      expDr = pos != 0 && lCmd;
      expCmd = regWr && regAddr == `SSO_REG_CTRL && regWdata[0];
    end
  end

  // Settled outputs are compared with the model every cycle.
  always @(negedge clk) begin
    if (!rst) begin
      `CHK(lA, expA)
      `CHK(lB, expB)
      `CHK(on, st == 2)
      `CHK(kA, expA)
      `CHK(kB, expB)
      `CHK(eFlt, flt)
      `CHK(dRst, expDr)
      `CHK(lCmd, expCmd)
    end
  end

  // ****************************************************************
  // Stimulus helpers
  // ****************************************************************
  function automatic logic upd(input logic c, input logic [7:0] x);
    return x == 8'h0 ? 1'b0 : x[2:0] == 3'h1 ? 1'b1 : c;
  endfunction

  // Read with the data taken in the one cycle it stands.
  task automatic bus_rd(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    `CHK(regRdata & m, e)
  endtask

  // Reset, pick a variant, then drive noisy inputs for n cycles.
  task automatic phase(input logic [1:0] v, input logic em, input int n);
    logic [31:0] r, q;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    variant <= sso_variant_e'(v);
    emon <= em;
    pos <= 5'($urandom);
    regAddr <= `SSO_REG_CTRL;
    repeat (n) begin
      @(posedge clk);
      r = $urandom;
      q = $urandom;
      inA <= upd(inA, r[7:0]);
      inB <= upd(inB, r[15:8]);
      act <= upd(act, r[23:16]);
      healthy <= upd(healthy, r[31:24]);
      fb <= upd(fb, q[7:0]);
      btn <= q[10:8] == 3'h0 ? !btn : btn;
      ack <= q[15:11] == 5'h0;
      dfn <= q[16];
      // Writes are spaced so command pulses never merge.
      regWr <= !regWr && q[21:17] == 5'h0;
      regWdata <= {30'h0, q[23:22]};
    end
    // Let the last random values be taken before the strobe is dropped.
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic complete_run;
    if (errors == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h6e5379b5));
    // The first phase keeps reset asserted over the second edge.
    @(posedge clk);
    phase(2'd0, 1'b1, 600);
    phase(2'd1, 1'b1, 600);
    phase(2'd2, 1'b1, 900);
    phase(2'd2, 1'b0, 300);
    phase(2'd3, 1'b1, 200);
    phase(2'd0, 1'b0, 0);
    inA <= 1'b1;
    inB <= 1'b1;
    act <= 1'b1;
    dfn <= 1'b0;
    pos <= 5'd31;
    repeat (6) @(posedge clk);
    // Test pulses must be blanked by the monitor.
    for (int i = 0; i < 90; i++) begin
      @(negedge clk);
      `CHK(machineEnable, 1'b1)
    end
    `CHK(shortEnable, 1'b0)
    bus_rd(`SSO_REG_STATUS, 32'h1B, 32'h19);
    `CHK(shortRdata[`SSO_ST_DISCREP], 1'b1)
    bus_rd(`SSO_REG_CTRL, 32'hFFFFFFFF, 32'h0);
    bus_rd(4'hC, 32'hFFFFFFFF, 32'h0);
    @(posedge clk);
    dfn <= 1'b1;
    repeat (2) @(posedge clk);
    bus_rd(`SSO_REG_STATUS, 32'h4, 32'h4);
    @(posedge clk);
    act <= 1'b0;
    for (int i = 0; i < 20 && machineEnable !== 1'b0; i++) @(negedge clk);
    `CHK(machineEnable, 1'b0)
    bus_rd(`SSO_REG_STATUS, 32'h19, 32'h0);
    complete_run();
  end
endmodule
